// ===== core/dou_mac.sv
`timescale 1ns/100ps
`default_nettype none
module dou_mac
  import dou_pkg::*;
(
  input wire logic [15:0] i_x, // multiplicand
  input wire logic [15:0] i_y, // multiplier
  input wire dou_mode_t i_mode, // signedness
  input wire dou_accsh_t i_acc_sh, // accumulator pre-shift
  input wire logic i_sub, // subtract product
  input wire logic [39:0] i_acc, // 40-bit addend
  output logic [39:0] o_res, // 40-bit result
  output logic o_ovf // result overflow
);
  // =====================================================
  // multiply, pre-shift, accumulate
  logic signed [16:0] x_ext;
  logic signed [16:0] y_ext;
  logic signed [33:0] prod;
  logic signed [40:0] acc_s;
  logic signed [40:0] sum;
  always_comb
  begin
    x_ext = {(i_mode != DOU_UU) & i_x[15], i_x}; // RULE_09
    y_ext = {(i_mode == DOU_SS) & i_y[15], i_y}; // RULE_09
    prod = x_ext * y_ext; // RULE_08
    case (i_acc_sh) // RULE_10
      DOU_ACC_SR1: acc_s = 41'(signed'(i_acc) >>> 1);
      DOU_ACC_SR16: acc_s = 41'(signed'(i_acc) >>> 16);
      default: acc_s = 41'(signed'(i_acc));
    endcase
    // one extra bit keeps the true sum for the overflow test
    sum = i_sub ? acc_s - 41'(prod) : acc_s + 41'(prod); // RULE_08
    o_res = sum[39:0];
    o_ovf = sum[40] ^ sum[39];
  end
endmodule
`default_nettype wire

// ===== core/dou_pkg.sv
package dou_pkg;
  // =====================================================
  // widths and register split
  localparam int DOU_W = 40;
  localparam int DOU_NREG = 8;
  localparam int DOU_LO_MSB = 15;
  localparam int DOU_HI_LSB = 16;
  localparam int DOU_HI_MSB = 31;
  localparam int DOU_EX_LSB = 32;
  localparam int DOU_SAC_W = 5;
  localparam logic [39:0] DOU_REG_RESET = 40'h00_0000_0000;
  localparam logic DOU_OVF_RESET = 1'b0;

  // =====================================================
  // operation codes
  typedef enum logic [4:0] {
    DOU_NOP, DOU_ADD, DOU_SUB, DOU_AND, DOU_OR, DOU_XOR, DOU_NOT, DOU_NEG,
    DOU_MOV, DOU_ABS, DOU_MAC_ADD, DOU_MAC_SUB, DOU_MUL, DOU_SRA, DOU_SRL,
    DOU_SLL, DOU_EXP, DOU_SHIFT_NORM
  } dou_op_t;

  typedef enum logic [1:0] {DOU_SS, DOU_SU, DOU_UU} dou_mode_t;
  typedef enum logic [1:0] {DOU_ACC_NONE, DOU_ACC_SR1, DOU_ACC_SR16} dou_accsh_t;
  typedef enum logic [2:0] {
    DOU_CC_ALWAYS, DOU_CC_EQ, DOU_CC_NE, DOU_CC_GT, DOU_CC_GE, DOU_CC_LT, DOU_CC_LE
  } dou_cond_t;
  // load/store view of a register
  typedef enum logic [2:0] {
    DOU_V_NONE, DOU_V_LOW, DOU_V_HIGH, DOU_V_EXT, DOU_V_SEXT
  } dou_view_t;

  // =====================================================
  // decoded instruction from the decoder
  typedef struct packed {
    logic valid;
    dou_op_t op;
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic [2:0] dst;
    logic use_imm;
    logic [15:0] imm;
    dou_mode_t mode;
    dou_accsh_t acc_sh;
    dou_cond_t cond;
    logic [2:0] cond_reg;
  } dou_instr_t;

  // load/store/transfer request
  typedef struct packed {
    logic ld_valid;
    dou_view_t ld_view;
    logic [2:0] ld_reg;
    logic [15:0] ld_data;
    dou_view_t st_view;
    logic [2:0] st_reg;
  } dou_mem_t;
endpackage

// ===== core/dou_sac.sv
`timescale 1ns/100ps
`default_nettype none
module dou_sac
  import dou_pkg::*;
(
  input wire logic [31:0] i_val, // 32-bit value to normalise
  output logic [39:0] o_cnt // shift count, upper bits zero
);
  // =====================================================
  // count redundant sign bits
  logic [4:0] cnt;
  logic run;
  always_comb
  begin
    cnt = 5'h00;
    run = 1'b1;
    for (int i = 30; i >= 0; i--)
    begin
      if (run && (i_val[i] == i_val[31]))
        cnt = cnt + 5'h01;
      else
        run = 1'b0;
    end
    o_cnt = {35'h0, cnt}; // RULE_13
  end
endmodule
`default_nettype wire

// ===== core/dou_unit.sv
// Operation
// RULE_01 - eight 40-bit registers split into low 15..0, high 31..16 and extension 39..32.
// RULE_02 - operations, condition tests and sign-extended loads use the whole 40 bits.
// RULE_03 - the exponent instruction reads only bits 31..0 of its operand.
// RULE_04 - a sign-extended load writes bits 39..16 as one 24-bit field.
// RULE_05 - bits 31..16 feed signed multiplier inputs and load/store of the high half.
// RULE_06 - bits 15..0 feed unsigned multiplier inputs, shift amounts, transfers and counts.
// RULE_07 - bits 39..32 are an 8-bit load/store source or destination.
// RULE_08 - the multiply-accumulator forms 16x16 product plus or minus a 40-bit value.
// RULE_09 - multiply supports signed-signed, signed-unsigned and unsigned-unsigned.
// RULE_10 - the accumulation operand may be shifted right arithmetically by 1 or 16.
// RULE_11 - the arithmetic-logic unit works on 40-bit inputs and outputs.
// RULE_12 - the barrel shifter does left, arithmetic right and logical right shifts.
// RULE_13 - the normalisation counter takes 32 bits and returns 40 bits with 39..5 zero.
// RULE_14 - a conditional instruction runs only when its 40-bit condition holds.
// RULE_15 - the previous result is forwarded to the operands without a stall.
// RULE_16 - overflow sets a sticky flag that a clean result never clears.
// RULE_17 - a 16-bit or 8-bit write leaves the rest of the register untouched.
`timescale 1ns/100ps
`default_nettype none
module dou_unit
  import dou_pkg::*;
#(
  parameter int NREG = DOU_NREG
)
(
  input wire logic i_clk, // system clock
  input wire logic i_resetn, // synchronous reset, active low
  input wire dou_instr_t i_instr, // decoded operation
  input wire dou_mem_t i_mem, // load/store request
  output logic [15:0] o_st_data, // store data word
  output logic o_st_valid, // store data valid
  output logic o_ovf, // sticky overflow flag
  output logic o_cond_true, // last condition result
  output logic [15:0] o_loop_cnt, // repeat count view
  output logic [39:0] o_result // last written result
);
  // =====================================================
  // elaboration check
  if (NREG != 8)
  begin : g_bad_nreg
    $error("dou_unit: only eight registers are supported");
  end

  // =====================================================
  // state
  logic [39:0] gp_regs [NREG]; // RULE_01
  logic [39:0] next_gp_regs [NREG];
  logic overflow_flag;
  logic next_overflow_flag;
  logic [39:0] fwd_val;
  logic [2:0] fwd_reg;
  logic fwd_ok;
  logic next_fwd_ok;
  logic [39:0] next_fwd_val;
  logic [2:0] next_fwd_reg;
  logic [15:0] st_data;
  logic next_st_valid;
  logic cond_q;
  logic next_cond_q;
  logic [15:0] loop_q;
  logic [15:0] next_loop_q;

  // register read with forwarding of the last result
  function automatic logic [39:0] rd(input logic [2:0] idx, input logic [39:0] file_val,
                                     input logic ok, input logic [2:0] fr, input logic [39:0] fv);
    rd = (ok && fr == idx) ? fv : file_val; // RULE_15
  endfunction

  // condition judge over a 40-bit value
  function automatic logic judge(input dou_cond_t c, input logic [39:0] v);
    logic z;
    logic n;
    z = (v == 40'h0);
    n = v[39];
    case (c)
      DOU_CC_EQ: judge = z;
      DOU_CC_NE: judge = !z;
      DOU_CC_GT: judge = !z && !n;
      DOU_CC_GE: judge = !n;
      DOU_CC_LT: judge = n;
      DOU_CC_LE: judge = n || z;
      default: judge = 1'b1;
    endcase
  endfunction

  // =====================================================
  // operand fetch
  logic [39:0] opa;
  logic [39:0] opb;
  logic [39:0] opd;
  logic [39:0] opc;
  always_comb
  begin
    opa = rd(i_instr.src_a, gp_regs[i_instr.src_a], fwd_ok, fwd_reg, fwd_val); // RULE_02
    opb = i_instr.use_imm ? {{24{i_instr.imm[15]}}, i_instr.imm}
        : rd(i_instr.src_b, gp_regs[i_instr.src_b], fwd_ok, fwd_reg, fwd_val);
    opd = rd(i_instr.dst, gp_regs[i_instr.dst], fwd_ok, fwd_reg, fwd_val);
    opc = rd(i_instr.cond_reg, gp_regs[i_instr.cond_reg], fwd_ok, fwd_reg, fwd_val);
  end

  // multiplier views: high half when signed, low half when unsigned
  logic [15:0] mx;
  logic [15:0] my;
  logic [39:0] mac_res;
  logic mac_ovf;
  logic mac_on;
  always_comb
  begin
    mx = (i_instr.mode == DOU_UU) ? opa[DOU_LO_MSB:0] : opa[DOU_HI_MSB:DOU_HI_LSB]; // RULE_05 RULE_06
    my = (i_instr.mode == DOU_SS) ? opb[DOU_HI_MSB:DOU_HI_LSB] : opb[DOU_LO_MSB:0]; // RULE_05 RULE_06
    mac_on = (i_instr.op == DOU_MAC_ADD) || (i_instr.op == DOU_MAC_SUB);
  end

  dou_mac u_mac (
    .i_x(mx),
    .i_y(my),
    .i_mode(i_instr.mode),
    .i_acc_sh(i_instr.acc_sh),
    .i_sub(i_instr.op == DOU_MAC_SUB),
    .i_acc(mac_on ? opd : 40'h0),
    .o_res(mac_res),
    .o_ovf(mac_ovf)
  );

  logic [39:0] sac_cnt;
  dou_sac u_sac (
    .i_val(opa[DOU_HI_MSB:0]), // RULE_03
    .o_cnt(sac_cnt)
  );

  // =====================================================
  // alu and barrel shifter
  logic [40:0] wide;
  logic [39:0] res;
  logic res_ovf;
  logic writes;
  logic [5:0] sh;
  always_comb
  begin
    // shift amount from the low half, clipped to the word width
    sh = (opb[DOU_LO_MSB:0] > 16'h28) ? 6'h28 : opb[5:0]; // RULE_06
    wide = 41'h0;
    res = 40'h0;
    res_ovf = 1'b0;
    writes = 1'b1;
    case (i_instr.op)
      DOU_ADD:
      begin
        wide = {opa[39], opa} + {opb[39], opb}; // RULE_11
        res = wide[39:0];
        res_ovf = wide[40] ^ wide[39];
      end
      DOU_SUB:
      begin
        wide = {opa[39], opa} - {opb[39], opb}; // RULE_11
        res = wide[39:0];
        res_ovf = wide[40] ^ wide[39];
      end
      DOU_NEG:
      begin
        wide = 41'h0 - {opa[39], opa};
        res = wide[39:0];
        res_ovf = wide[40] ^ wide[39];
      end
      DOU_ABS:
      begin
        wide = opa[39] ? 41'h0 - {opa[39], opa} : {opa[39], opa};
        res = wide[39:0];
        res_ovf = wide[40] ^ wide[39];
      end
      DOU_AND: res = opa & opb;
      DOU_OR: res = opa | opb;
      DOU_XOR: res = opa ^ opb;
      DOU_NOT: res = ~opa;
      DOU_MOV: res = opa;
      DOU_MAC_ADD, DOU_MAC_SUB, DOU_MUL:
      begin
        res = mac_res;
        res_ovf = mac_ovf;
      end
      DOU_SRA: res = 40'(signed'(opa) >>> sh); // RULE_12
      DOU_SRL: res = opa >> sh; // RULE_12
      DOU_SLL: res = opa << sh; // RULE_12
      DOU_EXP: res = sac_cnt; // RULE_13
      DOU_SHIFT_NORM: res = opa << sac_cnt[DOU_SAC_W-1:0];
      default: writes = 1'b0;
    endcase
  end

  // =====================================================
  // next state: write back, loads, flags
  logic run;
  logic [39:0] lreg;
  always_comb
  begin
    run = i_instr.valid && judge(i_instr.cond, opc); // RULE_14
    next_cond_q = i_instr.valid ? judge(i_instr.cond, opc) : cond_q;
    for (int i = 0; i < NREG; i++)
      next_gp_regs[i] = gp_regs[i];
    next_overflow_flag = overflow_flag;
    next_fwd_ok = 1'b0;
    next_fwd_reg = fwd_reg;
    next_fwd_val = fwd_val;
    if (run && writes)
    begin
      next_gp_regs[i_instr.dst] = res;
      next_fwd_ok = 1'b1;
      next_fwd_reg = i_instr.dst;
      next_fwd_val = res;
      if (res_ovf)
        next_overflow_flag = 1'b1; // RULE_16
    end
    // a load lands after the operation result of the same cycle
    lreg = next_gp_regs[i_mem.ld_reg];
    if (i_mem.ld_valid)
    begin
      case (i_mem.ld_view)
        DOU_V_LOW: lreg[DOU_LO_MSB:0] = i_mem.ld_data; // RULE_06 RULE_17
        DOU_V_HIGH: lreg[DOU_HI_MSB:DOU_HI_LSB] = i_mem.ld_data; // RULE_05 RULE_17
        DOU_V_EXT: lreg[39:DOU_EX_LSB] = i_mem.ld_data[7:0]; // RULE_07 RULE_17
        DOU_V_SEXT: lreg = {{8{i_mem.ld_data[15]}}, i_mem.ld_data, 16'h0}; // RULE_02 RULE_04
        default: lreg = lreg;
      endcase
      next_gp_regs[i_mem.ld_reg] = lreg;
      next_fwd_ok = 1'b1;
      next_fwd_reg = i_mem.ld_reg;
      next_fwd_val = lreg;
    end
    // store reads the register file before this cycle's write
    case (i_mem.st_view)
      DOU_V_LOW: st_data = gp_regs[i_mem.st_reg][DOU_LO_MSB:0]; // RULE_06
      DOU_V_HIGH: st_data = gp_regs[i_mem.st_reg][DOU_HI_MSB:DOU_HI_LSB]; // RULE_05
      DOU_V_EXT: st_data = {8'h0, gp_regs[i_mem.st_reg][39:DOU_EX_LSB]}; // RULE_07
      default: st_data = 16'h0;
    endcase
    next_st_valid = (i_mem.st_view == DOU_V_LOW) || (i_mem.st_view == DOU_V_HIGH)
                 || (i_mem.st_view == DOU_V_EXT);
    next_loop_q = gp_regs[i_instr.src_a][DOU_LO_MSB:0]; // RULE_06
  end

  // =====================================================
  // registers
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < NREG; i++)
        gp_regs[i] <= DOU_REG_RESET;
      overflow_flag <= DOU_OVF_RESET;
      fwd_ok <= 1'b0;
      fwd_reg <= 3'h0;
      fwd_val <= 40'h0;
      o_st_data <= 16'h0;
      o_st_valid <= 1'b0;
      cond_q <= 1'b0;
      loop_q <= 16'h0;
    end
    else
    begin
      for (int i = 0; i < NREG; i++)
        gp_regs[i] <= next_gp_regs[i];
      overflow_flag <= next_overflow_flag;
      fwd_ok <= next_fwd_ok;
      fwd_reg <= next_fwd_reg;
      fwd_val <= next_fwd_val;
      o_st_data <= st_data;
      o_st_valid <= next_st_valid;
      cond_q <= next_cond_q;
      loop_q <= next_loop_q;
    end
  end

  // outputs straight from flip-flops
  assign o_ovf = overflow_flag;
  assign o_cond_true = cond_q;
  assign o_loop_cnt = loop_q;
  assign o_result = fwd_val;

  // =====================================================
  // checks
  property p_ovf_sticky;
    @(posedge i_clk) disable iff (!i_resetn) overflow_flag |=> overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared"); // RULE_16

  property p_ovf_set;
    @(posedge i_clk) disable iff (!i_resetn) (run && writes && res_ovf) |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not recorded"); // RULE_16

  property p_suppress;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_instr.valid && !run && !i_mem.ld_valid) |=> (gp_regs[$past(i_instr.dst)] == $past(gp_regs[i_instr.dst]));
  endproperty
  a_suppress: assert property (p_suppress) else $error("false condition wrote a register"); // RULE_14

  // watched at the output so a wide count leaking through the result path is caught
  property p_sac_zero;
    @(posedge i_clk) disable iff (!i_resetn)
      (run && writes && i_instr.op == DOU_EXP && !i_mem.ld_valid) |=> (o_result[39:5] == 35'h0);
  endproperty
  a_sac_zero: assert property (p_sac_zero) else $error("normalise count too wide"); // RULE_13

  // the very next instruction must see the value written one cycle before
  property p_fwd;
    @(posedge i_clk) disable iff (!i_resetn)
      (run && writes && !i_mem.ld_valid) |=>
        (!i_instr.valid || i_instr.src_a != $past(i_instr.dst) || opa == $past(res));
  endproperty
  a_fwd: assert property (p_fwd) else $error("forwarded value differs from written value"); // RULE_15

  property p_sext;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_mem.ld_valid && i_mem.ld_view == DOU_V_SEXT) |=> (gp_regs[$past(i_mem.ld_reg)][15:0] == 16'h0
        && gp_regs[$past(i_mem.ld_reg)][39:16] == {{8{$past(i_mem.ld_data[15])}}, $past(i_mem.ld_data)});
  endproperty
  a_sext: assert property (p_sext) else $error("sign-extended load wrong"); // RULE_04

  property p_low_keep;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_mem.ld_valid && i_mem.ld_view == DOU_V_LOW && !(run && writes)) |=>
        (gp_regs[$past(i_mem.ld_reg)][39:16] == $past(gp_regs[i_mem.ld_reg][39:16]));
  endproperty
  a_low_keep: assert property (p_low_keep) else $error("low load disturbed upper bits"); // RULE_17

  property p_store_ext;
    @(posedge i_clk) disable iff (!i_resetn)
      (i_mem.st_view == DOU_V_EXT) |=> (o_st_valid && o_st_data == {8'h0, $past(gp_regs[i_mem.st_reg][39:32])});
  endproperty
  a_store_ext: assert property (p_store_ext) else $error("extension store wrong"); // RULE_07
endmodule
`default_nettype wire

// ===== verif/dou_dec_model.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// decoder and load/store side facing the operation unit
module dou_dec_model
  import dou_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_st_valid, // store strobe from the unit
  input wire logic [15:0] i_st_data, // store word from the unit
  output var dou_instr_t o_instr, // decoded operation
  output var dou_mem_t o_mem // load/store request
);
  logic [15:0] last_word;

  // idle bus at time zero, nothing valid
  initial
  begin
    o_instr = '0;
    o_mem = '0;
    last_word = 16'h0;
  end

  // memory side keeps the latest word the unit stored
  always @(posedge i_clk)
  begin
    if (i_st_valid)
      last_word <= i_st_data;
  end

  // requests change just after an edge and stand until the next one
  task automatic issue(input dou_instr_t ins);
    o_instr = ins;
    @(posedge i_clk);
    #1;
  endtask

  task automatic load(input dou_view_t v, input logic [2:0] r, input logic [15:0] d);
    o_mem.ld_valid = 1'b1;
    o_mem.ld_view = v;
    o_mem.ld_reg = r;
    o_mem.ld_data = d;
    @(posedge i_clk);
    #1;
  endtask

  task automatic store(input dou_view_t v, input logic [2:0] r);
    o_mem.st_view = v;
    o_mem.st_reg = r;
    @(posedge i_clk);
    #1;
  endtask

  // released data is inverted so a stale word can never look valid
  task automatic idle();
    o_instr.valid = 1'b0;
    o_mem.ld_valid = 1'b0;
    o_mem.ld_data = ~o_mem.ld_data;
    o_mem.st_view = DOU_V_NONE;
    @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== verif/test_dou_unit.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// self-checking bench for the operation unit
module test_dou_unit
  import dou_pkg::*;
;
  logic clk;
  logic resetn;
  dou_instr_t instr;
  dou_mem_t mem;
  logic [15:0] st_data;
  logic [15:0] loop_cnt;
  logic st_valid;
  logic ovf;
  logic cond_true;
  logic [39:0] result;
  int n_fail;
  int cmp_count;
  dou_mode_t g_mode;
  dou_accsh_t g_acc;
  dou_cond_t g_cond;
  logic [2:0] g_creg;

  dou_unit i_dou_unit (.i_clk(clk), .i_resetn(resetn), .i_instr(instr), .i_mem(mem), .o_st_data(st_data),
    .o_st_valid(st_valid), .o_ovf(ovf), .o_cond_true(cond_true), .o_loop_cnt(loop_cnt), .o_result(result));
  dou_dec_model i_dou_dec_model (.i_clk(clk), .i_st_valid(st_valid), .i_st_data(st_data), .o_instr(instr),
    .o_mem(mem));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // =====================================================
  // shared checks and transfers
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      n_fail++;
    end
  endtask

  task automatic run(input dou_op_t op, input logic [2:0] a, input logic [2:0] b, input logic [2:0] d,
    input logic ui, input logic [15:0] imm, input logic [39:0] exp);
    i_dou_dec_model.issue('{1'b1, op, a, b, d, ui, imm, g_mode, g_acc, g_cond, g_creg});
    chk(result, exp, op.name());
    i_dou_dec_model.idle();
  endtask

  task automatic ld(input dou_view_t v, input logic [2:0] r, input logic [15:0] d, input logic [39:0] exp);
    i_dou_dec_model.load(v, r, d);
    chk(result, exp, "load");
    i_dou_dec_model.idle();
  endtask

  // store strobe stands one cycle, then the word lands in memory
  task automatic st(input dou_view_t v, input logic [2:0] r, input logic [15:0] exp);
    i_dou_dec_model.store(v, r);
    chk({39'h0, st_valid}, 40'h1, "store strobe");
    chk({24'h0, st_data}, {24'h0, exp}, "store word");
    i_dou_dec_model.idle();
    chk({39'h0, st_valid}, 40'h0, "store strobe end");
    chk({24'h0, i_dou_dec_model.last_word}, {24'h0, exp}, "memory word");
  endtask

  // =====================================================
  // scenarios
  task automatic t_views();
    ld(DOU_V_SEXT, 3'h1, 16'h8001, 40'hff_8001_0000);
    ld(DOU_V_LOW, 3'h1, 16'h1234, 40'hff_8001_1234);
    ld(DOU_V_EXT, 3'h1, 16'h005a, 40'h5a_8001_1234);
    ld(DOU_V_HIGH, 3'h1, 16'h7777, 40'h5a_7777_1234);
    st(DOU_V_HIGH, 3'h1, 16'h7777);
    st(DOU_V_LOW, 3'h1, 16'h1234);
    st(DOU_V_EXT, 3'h1, 16'h005a);
    run(DOU_NOP, 3'h1, 3'h0, 3'h1, 1'b0, 16'h0, 40'h5a_7777_1234);
    chk({24'h0, loop_cnt}, 40'h1234, "repeat count");
    $display("test views done");
  endtask

  task automatic t_alu();
    dou_op_t ops[8] = '{DOU_ADD, DOU_SUB, DOU_AND, DOU_OR, DOU_XOR, DOU_NOT, DOU_NEG, DOU_ABS};
    logic [39:0] ex[8] = '{40'hff_8001_0003, 40'hff_8000_fffd, 40'h0, 40'hff_8001_0003, 40'hff_8001_0003,
      40'h00_7ffe_ffff, 40'h00_7fff_0000, 40'h00_7fff_0000};
    ld(DOU_V_SEXT, 3'h2, 16'h8001, 40'hff_8001_0000);
    foreach (ops[i])
      run(ops[i], 3'h2, 3'h0, 3'h3, 1'b1, 16'h0003, ex[i]);
    chk({39'h0, ovf}, 40'h0, "no overflow yet");
    // back to back: second add reads the result just written
    i_dou_dec_model.issue('{1'b1, DOU_ADD, 3'h2, 3'h0, 3'h3, 1'b1, 16'h1, g_mode, g_acc, g_cond, g_creg});
    i_dou_dec_model.issue('{1'b1, DOU_ADD, 3'h3, 3'h0, 3'h3, 1'b1, 16'h1, g_mode, g_acc, g_cond, g_creg});
    chk(result, 40'hff_8001_0002, "forwarded add");
    i_dou_dec_model.idle();
    $display("test alu done");
  endtask

  task automatic t_shift();
    ld(DOU_V_HIGH, 3'h4, 16'hffff, 40'h00_ffff_0000);
    ld(DOU_V_LOW, 3'h4, 16'h0004, 40'h00_ffff_0004);
    run(DOU_SRA, 3'h2, 3'h0, 3'h5, 1'b1, 16'h4, 40'hff_f800_1000);
    run(DOU_SRL, 3'h2, 3'h0, 3'h5, 1'b1, 16'h4, 40'h0f_f800_1000);
    run(DOU_SLL, 3'h2, 3'h0, 3'h5, 1'b1, 16'h4, 40'hf8_0010_0000);
    run(DOU_SLL, 3'h2, 3'h4, 3'h5, 1'b0, 16'h0, 40'hf8_0010_0000);
    run(DOU_MOV, 3'h4, 3'h0, 3'h5, 1'b0, 16'h0, 40'h00_ffff_0004);
    run(DOU_SHIFT_NORM, 3'h4, 3'h0, 3'h5, 1'b0, 16'h0, 40'hff_8002_0000);
    run(DOU_EXP, 3'h4, 3'h0, 3'h5, 1'b0, 16'h0, 40'h00_0000_000f);
    $display("test shift done");
  endtask

  task automatic t_mac();
    ld(DOU_V_HIGH, 3'h5, 16'h0002, 40'h00_0002_000f);
    ld(DOU_V_LOW, 3'h5, 16'hfffe, 40'h00_0002_fffe);
    ld(DOU_V_HIGH, 3'h6, 16'hfffd, 40'h00_fffd_0000);
    ld(DOU_V_LOW, 3'h6, 16'h0003, 40'h00_fffd_0003);
    ld(DOU_V_SEXT, 3'h7, 16'h0001, 40'h00_0001_0000);
    run(DOU_MUL, 3'h5, 3'h6, 3'h0, 1'b0, 16'h0, 40'hff_ffff_fffa);
    g_mode = DOU_SU;
    run(DOU_MUL, 3'h5, 3'h6, 3'h0, 1'b0, 16'h0, 40'h00_0000_0006);
    g_mode = DOU_UU;
    run(DOU_MUL, 3'h5, 3'h6, 3'h0, 1'b0, 16'h0, 40'h00_0002_fffa);
    g_mode = DOU_SS;
    run(DOU_MAC_ADD, 3'h5, 3'h6, 3'h7, 1'b0, 16'h0, 40'h00_0000_fffa);
    run(DOU_MAC_SUB, 3'h5, 3'h6, 3'h7, 1'b0, 16'h0, 40'h00_0001_0000);
    g_acc = DOU_ACC_SR16;
    run(DOU_MAC_ADD, 3'h5, 3'h6, 3'h7, 1'b0, 16'h0, 40'hff_ffff_fffb);
    g_acc = DOU_ACC_SR1;
    run(DOU_MAC_ADD, 3'h5, 3'h6, 3'h7, 1'b0, 16'h0, 40'hff_ffff_fff7);
    g_acc = DOU_ACC_NONE;
    $display("test mac done");
  endtask

  task automatic t_cond();
    logic [39:0] cur;
    logic [6:0] taken;
    cur = 40'h00_0002_fffa;
    taken = 7'b110_0101;
    g_creg = 3'h2;
    for (int c = 0; c < 7; c++)
    begin
      g_cond = dou_cond_t'(c);
      cur = cur + {39'h0, taken[c]};
      run(DOU_ADD, 3'h0, 3'h0, 3'h0, 1'b1, 16'h1, cur);
      chk({39'h0, cond_true}, {39'h0, taken[c]}, "condition");
    end
    g_cond = DOU_CC_ALWAYS;
    $display("test cond done");
  endtask

  task automatic t_ovf();
    ld(DOU_V_SEXT, 3'h1, 16'h7fff, 40'h00_7fff_0000);
    run(DOU_SLL, 3'h1, 3'h0, 3'h1, 1'b1, 16'h8, 40'h7f_ff00_0000);
    chk({39'h0, ovf}, 40'h0, "shift leaves flag");
    run(DOU_ADD, 3'h1, 3'h1, 3'h1, 1'b0, 16'h0, 40'hff_fe00_0000);
    chk({39'h0, ovf}, 40'h1, "overflow set");
    run(DOU_ADD, 3'h3, 3'h0, 3'h3, 1'b1, 16'h1, 40'hff_8001_0003);
    chk({39'h0, ovf}, 40'h1, "flag sticky");
    g_cond = DOU_CC_EQ;
    run(DOU_ADD, 3'h3, 3'h0, 3'h3, 1'b1, 16'h1, 40'hff_8001_0003);
    g_cond = DOU_CC_ALWAYS;
    $display("test overflow done");
  endtask

  // =====================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: whole run needs about 115 cycles
  initial
  begin
    #(25 * 3000);
    $display("Error at %0t: run did not finish", $time);
    n_fail++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    n_fail = 0;
    cmp_count = 0;
    g_mode = DOU_SS;
    g_acc = DOU_ACC_NONE;
    g_cond = DOU_CC_ALWAYS;
    g_creg = 3'h0;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk(result, DOU_REG_RESET, "reset result");
    chk({39'h0, ovf}, {39'h0, DOU_OVF_RESET}, "reset flag");
    t_views();
    t_alu();
    t_shift();
    t_mac();
    t_cond();
    t_ovf();
    report_and_stop();
  end
endmodule
`default_nettype wire
